// [rtl/pcd_defines.svh]
// How it works
// - Gate pin high lets the divided clock run freely on the main clock pin.
// - Gate low stops main clock at once if low, else at next fall.
// - While gated off the oscillator and prescaler keep running and the divider counter stays cleared.
// - After gate release the first main clock edge follows within one to two periods.
// - Pin role bit 1 makes a low dual-role pin an active-low power-down request.
// - Power-down stops main output, then reference output, then oscillator; outputs float.
// - Power-down stops the oscillator and all reference buffers, whatever the source.
// - Pin role bit 0: dual-role pin picks reference, high internal, low external.
// - Reference output follows the reference mux, ignores gate, stops cleanly in power-down.
// - Reference disable bit 1 keeps reference output off; 0 drives the reference clock.
// - Programmed configuration words are stored in non-volatile memory automatically.
// - Configuration changes only by programming, effective after a later operating power-up.
// - Configuration is two nine-bit words: mode and prescale, and divider value.
// - Reference source bit 1 picks external reference, 0 internal, unless pin overrides.
// - Divider bypass bit 1 routes master clock straight out, ignoring the divisor.
// - Internal source with divider bypassed still passes through the prescaler.
// - Prescale bypass bit 1 skips the prescaler; 0 inserts it.
// - Inserted prescaler divides by four for ratio bit 0, by two for 1.
// - External reference is never prescaled; output is it divided by N or one.
// - Programming power-up takes serial data on main pin; operating power-up reloads it.
// - Divider divides by divisor field plus two, from 2 to 513.
// - Gate pin is sampled on master clock rises and combined with the divider output.
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// non-volatile word addresses
`define PCD_MODE_WORD_ADDR 1'h0
`define PCD_DIV_WORD_ADDR 1'h1

// mode word field positions
`define PCD_REF_SRC_BIT 0
`define PCD_DIV_BYPASS_BIT 1
`define PCD_PRESCALE_BYPASS_BIT 2
`define PCD_PRESCALE_RATIO_BIT 3
`define PCD_PIN_ROLE_BIT 4
`define PCD_REF_OUT_DISABLE_BIT 5

// factory contents of the non-volatile words
`define PCD_MODE_WORD_RESET 9'h00A
`define PCD_DIV_WORD_RESET 9'h000

// divisor offset and serial frame length
`define PCD_DIVISOR_OFFSET 10'h002
`define PCD_FRAME_BITS 4'hA

`endif

// [rtl/pcd_div.sv]
`include "pcd_defines.svh"

module pcd_div
    import pcd_pkg::*;
#(
    parameter int NW = 9
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // control
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic [NW-1:0] n_i,
    // divided clock
    output logic div_o
);
    logic [NW:0] cnt_q, cnt_d;
    logic out_q, out_d;
    logic [NW:0] divisor;

    assign divisor = {1'b0, n_i} + `PCD_DIVISOR_OFFSET;

    // count master clock rises; high for the first half of each divisor period
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (clear_i) begin
            cnt_d = divisor - 10'h001;
            out_d = 1'b0;
        end else if (tick_i) begin
            cnt_d = (cnt_q >= divisor - 10'h001) ? '0 : cnt_q + 10'h001;
            out_d = cnt_d < (divisor >> 1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign div_o = out_q;
endmodule : pcd_div

// [rtl/pcd_nvm.sv]
`include "pcd_defines.svh"

module pcd_nvm
    import pcd_pkg::*;
#(
    parameter int AW = 1,
    parameter int DW = 9,
    parameter logic [DW-1:0] MODE_INIT = `PCD_MODE_WORD_RESET,
    parameter logic [DW-1:0] DIV_INIT = `PCD_DIV_WORD_RESET
) (
    // clock
    input wire logic clk_i,
    // access port
    pcd_nvm_if.mem port
);
    // factory contents; the array is not touched by reset so it survives power cycles
    logic [DW-1:0] mem_q [2**AW] = '{`PCD_MODE_WORD_ADDR: MODE_INIT, `PCD_DIV_WORD_ADDR: DIV_INIT, default: '0};
    logic [DW-1:0] rdata_q;

    // committed words are stored at once, read data is registered
    always_ff @(posedge clk_i) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
        rdata_q <= mem_q[port.raddr];
    end

    assign port.rdata = rdata_q;
endmodule : pcd_nvm

// [rtl/pcd_nvm_if.sv]
interface pcd_nvm_if #(
    parameter int AW = 1,
    parameter int DW = 9
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : pcd_nvm_if

// [rtl/pcd_pkg.sv]
package pcd_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        ST_LOAD_MODE,
        ST_LOAD_DIV,
        ST_LOAD_END,
        ST_RUN,
        ST_PD_OUT,
        ST_PD_REF,
        ST_PD_OSC,
        ST_DOWN,
        ST_PROG
    } pcd_state_t;

    // reference multiplexer selection
    typedef enum logic [1:0] {
        SRC_INT,
        SRC_EXT,
        SRC_NONE
    } pcd_src_t;

endpackage : pcd_pkg

// [rtl/pcd_top.sv]
`include "pcd_defines.svh"

module pcd_top
    import pcd_pkg::*;
#(
    parameter int NW = 9,
    parameter int OSC_HALF = 1,
    parameter logic [NW-1:0] MODE_INIT = `PCD_MODE_WORD_RESET,
    parameter logic [NW-1:0] DIV_INIT = `PCD_DIV_WORD_RESET
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // power-up mode strap, high for programming
    input wire logic prog_mode_i,
    // gate and dual-role pins
    input wire logic output_enable_i,
    input wire logic dual_role_pin_i,
    // external reference or crystal
    input wire logic ext_ref_pin_i,
    output logic crystal_pin_en_o,
    // dual-purpose main clock pin
    input wire logic main_clk_i,
    output logic main_clk_o,
    output logic main_clk_oe_o,
    // reference clock pin
    output logic reference_clock_pin_o,
    output logic reference_clock_pin_oe_o,
    // status
    output logic osc_run_o,
    output logic powered_down_o
);
    localparam int NS = 4;
    localparam int OW = 8;

    // pin synchronisers: three stages, a change counts once stages two and three agree
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1_q, s2_q, s3_q, st_q, st_d;

    assign pin_raw = {main_clk_i, ext_ref_pin_i, dual_role_pin_i, output_enable_i};

    for (genvar i = 0; i < NS; i++) begin : g_sync
        always_comb begin
            st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_q <= 4'h2; // dual-role pin idles high: no false power-down after reset
            s2_q <= 4'h2;
            s3_q <= 4'h2;
            st_q <= 4'h2;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= st_d;
        end
    end

    logic gate_s, dual_s, ext_s, data_s;
    assign gate_s = st_q[0];
    assign dual_s = st_q[1];
    assign ext_s = st_q[2];
    assign data_s = st_q[3];

    // sequencer and configuration state
    pcd_state_t state_q, state_d;
    logic prog_q, prog_d;
    logic [NW-1:0] mode_q, mode_d;
    logic [NW-1:0] ndiv_q, ndiv_d;
    logic osc_on_q, osc_on_d;
    logic mclk_on_q, mclk_on_d;
    logic main_oe_q, main_oe_d;

    // mode word fields; upper three bits are ignored
    logic f_ref_src, f_div_byp, f_pre_byp, f_pre_ratio, f_pin_role, f_ref_dis;
    assign f_ref_src = mode_q[`PCD_REF_SRC_BIT];
    assign f_div_byp = mode_q[`PCD_DIV_BYPASS_BIT];
    assign f_pre_byp = mode_q[`PCD_PRESCALE_BYPASS_BIT];
    assign f_pre_ratio = mode_q[`PCD_PRESCALE_RATIO_BIT];
    assign f_pin_role = mode_q[`PCD_PIN_ROLE_BIT];
    assign f_ref_dis = mode_q[`PCD_REF_OUT_DISABLE_BIT];

    logic running;
    logic pd_req;
    logic want_ext;
    assign running = (state_q == ST_RUN);
    assign pd_req = f_pin_role && !dual_s;
    assign want_ext = f_pin_role ? f_ref_src : !dual_s;

    // on-chip oscillator model: toggles every OSC_HALF clocks while powered
    logic [OW-1:0] osc_cnt_q, osc_cnt_d;
    logic onchip_oscillator_q, onchip_oscillator_d;
    logic osc_rise;

    always_comb begin
        osc_cnt_d = osc_cnt_q;
        onchip_oscillator_d = onchip_oscillator_q;
        if (!osc_on_q) begin
            osc_cnt_d = '0;
            onchip_oscillator_d = 1'b0;
        end else if (osc_cnt_q == OW'(OSC_HALF - 1)) begin
            osc_cnt_d = '0;
            onchip_oscillator_d = !onchip_oscillator_q;
        end else begin
            osc_cnt_d = osc_cnt_q + 8'h01;
        end
    end

    assign osc_rise = onchip_oscillator_d && !onchip_oscillator_q;

    // prescaler on the internal path only: bit 0 halves, bit 1 quarters
    logic [1:0] pre_q, pre_d;
    logic internal_ref_clk;
    logic external_ref_clk;

    always_comb begin
        pre_d = pre_q;
        if (!osc_on_q) begin
            pre_d = '0;
        end else if (osc_rise) begin
            pre_d = pre_q + 2'h1;
        end
    end

    always_comb begin
        if (f_pre_byp) begin
            internal_ref_clk = onchip_oscillator_q;
        end else if (f_pre_ratio) begin
            internal_ref_clk = pre_q[0];
        end else begin
            internal_ref_clk = pre_q[1];
        end
    end

    // external path is the buffered pin level, never prescaled
    assign external_ref_clk = ext_s && osc_on_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            osc_cnt_q <= '0;
            onchip_oscillator_q <= 1'b0;
            pre_q <= '0;
        end else begin
            osc_cnt_q <= osc_cnt_d;
            onchip_oscillator_q <= onchip_oscillator_d;
            pre_q <= pre_d;
        end
    end

    // glitch-free reference mux: leave a source only while it is low, join the next only while it is low
    pcd_src_t src_q, src_d;
    logic mux_out, mclk, mclk_prev_q, mclk_rise;

    always_comb begin
        src_d = src_q;
        unique case (src_q)
            SRC_INT: begin
                if (want_ext && !internal_ref_clk) begin
                    src_d = SRC_NONE;
                end
            end
            SRC_EXT: begin
                if (!want_ext && !external_ref_clk) begin
                    src_d = SRC_NONE;
                end
            end
            SRC_NONE: begin
                if (want_ext && !external_ref_clk) begin
                    src_d = SRC_EXT;
                end else if (!want_ext && !internal_ref_clk) begin
                    src_d = SRC_INT;
                end
            end
            default: src_d = SRC_NONE;
        endcase
    end

    always_comb begin
        unique case (src_q)
            SRC_INT: mux_out = internal_ref_clk;
            SRC_EXT: mux_out = external_ref_clk;
            default: mux_out = 1'b0;
        endcase
    end

    assign mclk = mux_out && mclk_on_q;
    assign mclk_rise = mclk && !mclk_prev_q;

    // gate sampled on master clock rises, output enable waits for a low level
    logic gate_q, gate_d;
    logic en_q, en_d;
    logic div_out, src_out;
    logic main_q, main_d;
    logic ref_q, ref_d;

    always_comb begin
        gate_d = gate_q;
        if (!running) begin
            gate_d = 1'b0;
        end else if (mclk_rise) begin
            gate_d = gate_s;
        end
    end

    assign src_out = f_div_byp ? mclk : div_out;

    always_comb begin
        en_d = en_q;
        if (gate_q && !src_out) begin
            en_d = 1'b1;
        end else if (!gate_q && !main_q) begin
            en_d = 1'b0;
        end
    end

    always_comb begin
        main_d = src_out && en_q;
        ref_d = mclk && !f_ref_dis;
    end

    pcd_div #(
        .NW(NW)
    ) u_div (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(mclk_rise),
        .clear_i(!en_q),
        .n_i(ndiv_q),
        .div_o(div_out)
    );

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            src_q <= SRC_INT;
            mclk_prev_q <= 1'b0;
            gate_q <= 1'b0;
            en_q <= 1'b0;
            main_q <= 1'b0;
            ref_q <= 1'b0;
        end else begin
            src_q <= src_d;
            mclk_prev_q <= mclk;
            gate_q <= gate_d;
            en_q <= en_d;
            main_q <= main_d;
            ref_q <= ref_d;
        end
    end

    // serial programming: the dual-role pin clocks in an address bit then nine data bits
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [NW:0] shift_q, shift_d;
    logic dual_prev_q;
    logic sclk_rise;
    logic commit;

    assign sclk_rise = dual_s && !dual_prev_q;

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        commit = 1'b0;
        if (state_q == ST_PROG && sclk_rise) begin
            shift_d = {shift_q[NW-1:0], data_s};
            if (bit_cnt_q == `PCD_FRAME_BITS - 4'h1) begin
                bit_cnt_d = '0;
                commit = 1'b1;
            end else begin
                bit_cnt_d = bit_cnt_q + 4'h1;
            end
        end
    end

    // non-volatile words are reachable only through the serial port and the power-up load
    pcd_nvm_if #(.AW(1), .DW(NW)) nvm ();

    assign nvm.we = commit;
    assign nvm.waddr = shift_d[NW];
    assign nvm.wdata = shift_d[NW-1:0];
    assign nvm.raddr = (state_q == ST_LOAD_MODE) ? `PCD_MODE_WORD_ADDR : `PCD_DIV_WORD_ADDR;

    pcd_nvm #(
        .AW(1),
        .DW(NW),
        .MODE_INIT(MODE_INIT),
        .DIV_INIT(DIV_INIT)
    ) u_nvm (
        .clk_i(clk_i),
        .port(nvm)
    );

    // power-up load, power-down sequence and programming mode
    always_comb begin
        state_d = state_q;
        prog_d = prog_q;
        mode_d = mode_q;
        ndiv_d = ndiv_q;
        osc_on_d = osc_on_q;
        mclk_on_d = mclk_on_q;
        main_oe_d = main_oe_q;
        unique case (state_q)
            ST_LOAD_MODE: begin
                prog_d = prog_mode_i;
                state_d = ST_LOAD_DIV;
            end
            ST_LOAD_DIV: begin
                mode_d = nvm.rdata;
                state_d = ST_LOAD_END;
            end
            ST_LOAD_END: begin
                ndiv_d = nvm.rdata;
                if (prog_q) begin
                    state_d = ST_PROG;
                end else begin
                    osc_on_d = 1'b1;
                    mclk_on_d = 1'b1;
                    main_oe_d = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pd_req) begin
                    state_d = ST_PD_OUT;
                end
            end
            ST_PD_OUT: begin
                if (!en_q && !main_q) begin
                    main_oe_d = 1'b0;
                    state_d = ST_PD_REF;
                end
            end
            ST_PD_REF: begin
                if (!mclk) begin
                    mclk_on_d = 1'b0;
                    state_d = ST_PD_OSC;
                end
            end
            ST_PD_OSC: begin
                osc_on_d = 1'b0;
                state_d = ST_DOWN;
            end
            ST_DOWN: begin
                if (!pd_req) begin
                    osc_on_d = 1'b1;
                    mclk_on_d = 1'b1;
                    main_oe_d = 1'b1;
                    state_d = ST_RUN;
                end
            end
            ST_PROG: begin
                state_d = ST_PROG;
            end
            default: state_d = ST_LOAD_MODE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= ST_LOAD_MODE;
            prog_q <= 1'b0;
            mode_q <= '0;
            ndiv_q <= '0;
            osc_on_q <= 1'b0;
            mclk_on_q <= 1'b0;
            main_oe_q <= 1'b0;
            bit_cnt_q <= '0;
            shift_q <= '0;
            dual_prev_q <= 1'b1;
        end else begin
            state_q <= state_d;
            prog_q <= prog_d;
            mode_q <= mode_d;
            ndiv_q <= ndiv_d;
            osc_on_q <= osc_on_d;
            mclk_on_q <= mclk_on_d;
            main_oe_q <= main_oe_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            dual_prev_q <= dual_s;
        end
    end

    // pin drivers
    assign main_clk_o = main_q;
    assign main_clk_oe_o = main_oe_q;
    assign reference_clock_pin_o = ref_q;
    assign reference_clock_pin_oe_o = mclk_on_q && !f_ref_dis;
    assign crystal_pin_en_o = osc_on_q;
    assign osc_run_o = osc_on_q;
    assign powered_down_o = (state_q == ST_DOWN);
endmodule : pcd_top

// [tb/pcd_board_model.sv]
module pcd_board_model (
    // system clock
    input wire logic clk_i,
    // clocks from the block
    input wire logic main_clk_o,
    input wire logic reference_clock_pin_o,
    // external reference oscillator
    output logic ext_ref_pin_i,
    // measurements of the consumers
    output int main_period,
    output int main_rises,
    output int ref_period,
    output int ref_rises
);
    timeunit 1ns;
    timeprecision 1ns;
    int main_cnt;
    int ref_cnt;
    logic main_last;
    logic ref_last;

    // free-running oscillator, ten system clocks a period, off the clock edge
    initial begin
        ext_ref_pin_i = 1'b0;
        main_period = 0;
        main_rises = 0;
        ref_period = 0;
        ref_rises = 0;
        main_cnt = 0;
        ref_cnt = 0;
        main_last = 1'b1;
        ref_last = 1'b1;
        #13;
        forever begin
            #250;
            ext_ref_pin_i = ~ext_ref_pin_i;
        end
    end

    // consumers time rising edges in system clock cycles
    always @(posedge clk_i) begin
        main_last <= main_clk_o;
        ref_last <= reference_clock_pin_o;
        main_cnt <= main_cnt + 1;
        ref_cnt <= ref_cnt + 1;
        if (main_clk_o === 1'b1 && main_last === 1'b0) begin
            main_period <= main_cnt;
            main_rises <= main_rises + 1;
            main_cnt <= 1;
        end
        if (reference_clock_pin_o === 1'b1 && ref_last === 1'b0) begin
            ref_period <= ref_cnt;
            ref_rises <= ref_rises + 1;
            ref_cnt <= 1;
        end
    end
endmodule : pcd_board_model

// [tb/pcd_top_chk.sv]
module pcd_top_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // strap and pins
    input wire logic prog_mode_i,
    input wire logic output_enable_i,
    input wire logic dual_role_pin_i,
    // outputs of the block
    input wire logic main_clk_o,
    input wire logic main_clk_oe_o,
    input wire logic reference_clock_pin_o,
    input wire logic reference_clock_pin_oe_o,
    input wire logic osc_run_o,
    input wire logic crystal_pin_en_o,
    input wire logic powered_down_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] gate_low_q;
    logic [5:0] gate_low_d;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // consecutive cycles with the gate pin low, saturating
    always_comb begin
        gate_low_d = output_enable_i ? 6'h00 : (gate_low_q == 6'h3F ? gate_low_q : gate_low_q + 6'h01);
    end

    // register the gate counter
    always_ff @(posedge clk_i) begin
        gate_low_q <= resetn_i ? gate_low_d : 6'h00;
    end

    // power-down steps after the reference pin lets go
    sequence s_osc_stop;
        !osc_run_o && !crystal_pin_en_o;
    endsequence
    sequence s_pd_tail;
        s_osc_stop ##1 powered_down_o;
    endsequence

    property p_gate_stops;
        gate_low_q >= 6'h20 && !main_clk_o |=> !main_clk_o;
    endproperty
    a_gate_stops: assert property (p_gate_stops) else $error("main clock pulsed while gated");
    property p_gate_start;
        $rose(output_enable_i) && gate_low_q >= 6'h20 && main_clk_oe_o |->
            (!main_clk_o)[*4] ##[1:32] (main_clk_o || !output_enable_i || !main_clk_oe_o);
    endproperty
    a_gate_start: assert property (p_gate_start) else $error("bad first edge after gate release");
    property p_oe_fall_low;
        $fell(main_clk_oe_o) |-> !main_clk_o;
    endproperty
    a_oe_fall_low: assert property (p_oe_fall_low) else $error("main pin released while high");
    property p_pd_chain;
        $fell(reference_clock_pin_oe_o) |-> !main_clk_oe_o ##1 s_pd_tail;
    endproperty
    a_pd_chain: assert property (p_pd_chain) else $error("power-down steps out of order");
    property p_pd_quiet;
        powered_down_o |-> !main_clk_oe_o && !reference_clock_pin_oe_o && !osc_run_o && !crystal_pin_en_o;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("power-down left something on");
    property p_pd_wake;
        powered_down_o && $rose(dual_role_pin_i) |-> ##[1:10] (osc_run_o || !dual_role_pin_i);
    endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no wake from power-down");
    property p_pd_cause;
        $rose(powered_down_o) |-> !$past(dual_role_pin_i, 4);
    endproperty
    a_pd_cause: assert property (p_pd_cause) else $error("power-down without request");
    property p_prog_quiet;
        $rose(resetn_i) && prog_mode_i |-> (!main_clk_oe_o && !reference_clock_pin_oe_o)[*8];
    endproperty
    a_prog_quiet: assert property (p_prog_quiet) else $error("pins driven while programming");
    property p_load_first;
        $rose(resetn_i) |-> (!main_clk_oe_o && !osc_run_o)[*2];
    endproperty
    a_load_first: assert property (p_load_first) else $error("output before words loaded");
endmodule : pcd_top_chk

bind pcd_top pcd_top_chk u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .prog_mode_i(prog_mode_i), .output_enable_i(output_enable_i),
    .dual_role_pin_i(dual_role_pin_i), .main_clk_o(main_clk_o), .main_clk_oe_o(main_clk_oe_o),
    .reference_clock_pin_o(reference_clock_pin_o), .reference_clock_pin_oe_o(reference_clock_pin_oe_o),
    .osc_run_o(osc_run_o), .crystal_pin_en_o(crystal_pin_en_o), .powered_down_o(powered_down_o)
);

// [tb/tb_programmable_clock_divider_control.sv]
module tb_programmable_clock_divider_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] MODES [8] = '{9'h000, 9'h008, 9'h004, 9'h00E, 9'h011, 9'h001, 9'h020, 9'h000};
    localparam logic [8:0] DIVS [8] = '{9'h001, 9'h002, 9'h1FF, 9'h005, 9'h000, 9'h000, 9'h001, 9'h000};
    localparam logic [7:0] PINS = 8'h7F;
    logic clk_i;
    logic resetn_i;
    logic prog_mode_i;
    logic output_enable_i;
    logic dual_role_pin_i;
    logic prog_data;
    logic main_clk_i;
    logic ext_ref_pin_i;
    logic crystal_pin_en_o;
    logic main_clk_o;
    logic main_clk_oe_o;
    logic reference_clock_pin_o;
    logic reference_clock_pin_oe_o;
    logic osc_run_o;
    logic powered_down_o;
    int main_period;
    int main_rises;
    int ref_period;
    int ref_rises;
    int mismatches;
    int total_checks;
    int k;
    int r;

    // main pin level: the block's driver wins, else the programmer's data
    assign main_clk_i = main_clk_oe_o ? main_clk_o : prog_data;

    // system clock
    initial clk_i = 1'b0;
    always #25 clk_i = ~clk_i;

    pcd_top #(.OSC_HALF(1)) uut (
        .clk_i(clk_i), .resetn_i(resetn_i), .prog_mode_i(prog_mode_i), .output_enable_i(output_enable_i),
        .dual_role_pin_i(dual_role_pin_i), .ext_ref_pin_i(ext_ref_pin_i), .crystal_pin_en_o(crystal_pin_en_o),
        .main_clk_i(main_clk_i), .main_clk_o(main_clk_o), .main_clk_oe_o(main_clk_oe_o),
        .reference_clock_pin_o(reference_clock_pin_o), .reference_clock_pin_oe_o(reference_clock_pin_oe_o),
        .osc_run_o(osc_run_o), .powered_down_o(powered_down_o)
    );

    pcd_board_model board (
        .clk_i(clk_i), .main_clk_o(main_clk_o), .reference_clock_pin_o(reference_clock_pin_o),
        .ext_ref_pin_i(ext_ref_pin_i), .main_period(main_period), .main_rises(main_rises),
        .ref_period(ref_period), .ref_rises(ref_rises)
    );

    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask : check

    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic power_up(input logic prog, input logic pin);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        prog_mode_i <= prog;
        dual_role_pin_i <= pin;
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (20) @(posedge clk_i);
    endtask : power_up

    // one frame: address bit then nine data bits, msb first, shifted on pin rises
    task automatic prog_word(input logic addr, input logic [8:0] data);
        logic [9:0] frame;
        frame = {addr, data};
        for (int i = 9; i >= 0; i--) begin
            @(posedge clk_i);
            prog_data <= frame[i];
            repeat (6) @(posedge clk_i);
            dual_role_pin_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            dual_role_pin_i <= 1'b0;
        end
        repeat (10) @(posedge clk_i);
    endtask : prog_word

    task automatic configure(input logic [8:0] mode, input logic [8:0] n, input logic pin);
        power_up(1'b1, 1'b0);
        check(main_clk_oe_o === 1'b0, "main pin driven while programming");
        prog_word(1'b0, mode);
        prog_word(1'b1, n);
        power_up(1'b0, pin);
    endtask : configure

    task automatic measure(input int exp_p);
        int r0;
        int w;
        r0 = main_rises;
        w = 0;
        while (main_rises < r0 + 3 && w < 4000) begin
            @(posedge clk_i);
            w++;
        end
        check(main_period == exp_p, "main clock period");
    endtask : measure

    // expected periods worked out from the mode word and the pin
    task automatic cfg_check(input logic [8:0] mode, input logic [8:0] n, input logic pin);
        int mp;
        mp = (mode[4] ? mode[0] : !pin) ? 10 : (mode[2] ? 2 : (mode[3] ? 4 : 8));
        measure(mode[1] ? mp : mp * (int'(n) + 2));
        check(reference_clock_pin_oe_o === !mode[5], "reference pin enable");
        if (!mode[5]) check(ref_period == mp, "reference clock period");
    endtask : cfg_check

    // hang guard
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    // main sequence
    initial begin
        mismatches = 0;
        total_checks = 0;
        resetn_i = 1'b0;
        prog_mode_i = 1'b0;
        output_enable_i = 1'b1;
        dual_role_pin_i = 1'b1;
        prog_data = 1'b0;
        power_up(1'b0, 1'b1);
        cfg_check(9'h00A, 9'h000, 1'b1);
        for (int i = 0; i < 8; i++) begin
            configure(MODES[i], DIVS[i], PINS[i]);
            cfg_check(MODES[i], DIVS[i], PINS[i]);
        end
        // live switch back to the internal oscillator
        @(posedge clk_i);
        dual_role_pin_i <= 1'b1;
        cfg_check(9'h000, 9'h000, 1'b1);
        // gate off and on again
        configure(9'h000, 9'h001, 1'b1);
        @(posedge clk_i);
        output_enable_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        k = 0;
        r = ref_rises;
        repeat (40) begin
            @(posedge clk_i);
            if (main_clk_o !== 1'b0) k++;
        end
        check(k == 0, "main clock ran while gated");
        check(main_clk_oe_o === 1'b1 && ref_rises > r + 2, "reference stopped by gate");
        output_enable_i <= 1'b1;
        k = 0;
        while (main_clk_o !== 1'b1 && k < 60) begin
            @(posedge clk_i);
            k++;
        end
        check(k >= 5 && k <= 30, "first edge after gate release");
        measure(24);
        // power-down request and wake
        configure(9'h010, 9'h000, 1'b1);
        measure(16);
        @(posedge clk_i);
        dual_role_pin_i <= 1'b0;
        k = 0;
        while (powered_down_o !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        check(k < 100 && {main_clk_oe_o, reference_clock_pin_oe_o, osc_run_o, crystal_pin_en_o} === 4'h0,
              "power-down state");
        dual_role_pin_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        measure(16);
        give_verdict();
    end
endmodule : tb_programmable_clock_divider_control
